// [hw/ppm_pkg.sv]
// constants and types for the port pin mux and control block
package ppm_pkg;
    localparam int NUM_PORTS = 7;
    localparam int PORT_W = 8;
    localparam int PINS = NUM_PORTS * PORT_W;
    localparam int PORT0_W = 5;
    // port numbers
    localparam logic [2:0] PORT0 = 3'h0;
    localparam logic [2:0] PORT1 = 3'h1;
    localparam logic [2:0] PORT4 = 3'h4;
    // flat pin positions (port * 8 + bit)
    localparam int PIN_P00 = 0;
    localparam int PIN_P04 = 4;
    localparam int PIN_SERIAL0_IN = 21;
    localparam int PIN_AUTO_STROBE = 19;
    localparam int PIN_AUTO_BUSY = 20;
    localparam int PIN_SERIAL0_OUT = 22;
    localparam int PIN_SERIAL0_CLK = 23;
    localparam int PIN_TIMER16_OUT = 24;
    localparam int PIN_PROG_CE = 24;
    localparam int PIN_PROG_OE = 25;
    localparam int PIN_PROG_PGM = 26;
    localparam int PIN_PROG_A16 = 27;
    localparam int BASE_P1 = 8;
    localparam int BASE_P2 = 16;
    localparam int BASE_P4 = 32;
    localparam int BASE_P5 = 40;
    localparam int PIN_RD_N = 52;
    localparam int PIN_WR_N = 53;
    localparam int PIN_WAIT_N = 54;
    localparam int PIN_ADDR_LATCH = 55;
    localparam int OD_FIRST = 48;
    localparam int OD_LAST = 51;
    // reset values
    localparam logic [7:0] MEM_SIZE_RST = 8'hcf;
    localparam logic [7:0] EXP_RAM_SIZE_RST = 8'h0a;
    localparam logic [7:0] MODE_RST = 8'hff;
    localparam logic [7:0] LATCH_RST = 8'h00;
    localparam logic [7:0] PULLUP_RST = 8'h00;
    // edge select codes
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    typedef enum logic [1:0] {
        PPM_SIO_OFF,
        PPM_SIO_3WIRE,
        PPM_SIO_2WIRE,
        PPM_SIO_I2C
    } ppm_sio_mode_t;
    typedef enum logic [1:0] {
        PPM_BUS_IDLE,
        PPM_BUS_ADDR,
        PPM_BUS_STROBE,
        PPM_BUS_DONE
    } ppm_bus_state_t;
endpackage

// [hw/ppm_port_mux.sv]
// port pin mux and control: ports 0 to 6, alternate functions, prom mode entry
//
// Overview of operation
// - port 0 bits 0 and 4 are input only; bits 1 to 3 set direction singly.
// - port 4 direction is one setting for all eight bits together.
// - any falling edge on a port 4 pin sets the key return flag.
// - software pull-ups apply only to pins in input mode.
// - after reset every port and shared alternate pin is an input.
// - port 1 as analog inputs: software sets input mode, pull-ups drop automatically.
// - external interrupts 0 to 2 fire on rising, falling or both edges.
// - external interrupt 3 fires on falling edges only.
// - reset memory size gives 60 Kbytes program memory, 1024 bytes fast RAM.
// - reset expansion RAM size gives 1024 bytes.
// - supply pin high and reset pin low enter prom programming mode.
// - programming mode pins: 17-bit address, 8-bit data, enable, read, program.
// - external memory uses port 4 as low address/data and port 5 as high address.
// - external accesses drive an address latch strobe plus read and write strobes.
// - the wait input stretches an external access with wait states.
// - serial 0 pins serve as one-way, bus line or i2c data; clock doubles as i2c clock.
// - automatic transfer drives a strobe pin and samples a busy pin.
// - the 16-bit timer output replaces the port 3 bit 0 latch value on its pin when enabled.
`timescale 1ns/1ps
`default_nettype none
module ppm_port_mux #(
    parameter int PORT_WIDTH = 8
) (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic [55:0] i_pin_in,
    output logic [55:0] o_pin_out,
    output logic [55:0] o_pin_oe,
    output logic [55:0] o_pin_pullup,
    input wire logic [2:0] i_port_sel,
    input wire logic [7:0] i_wdata,
    input wire logic i_latch_wr,
    input wire logic i_mode_wr,
    input wire logic i_pullup_wr,
    output logic [7:0] o_port_rdata,
    input wire logic i_mem_size_wr,
    input wire logic i_exp_ram_size_wr,
    output logic [7:0] o_memory_size_select,
    output logic [7:0] o_expansion_ram_size_select,
    input wire logic i_feedback_resistor_cut,
    input wire logic i_analog_en,
    output logic o_key_return_flag,
    input wire logic i_key_return_clr,
    input wire logic [5:0] i_ext_irq_edge,
    output logic [3:0] o_ext_irq,
    input wire logic i_vpp_prog,
    input wire logic [7:0] i_prog_rdata,
    output logic o_prog_mode,
    output logic [16:0] o_prog_addr,
    output logic [7:0] o_prog_wdata,
    output logic o_prog_ce_n,
    output logic o_prog_oe_n,
    output logic o_prog_pgm_n,
    input wire logic i_ext_bus_en,
    input wire logic i_ext_rd_req,
    input wire logic i_ext_wr_req,
    input wire logic [15:0] i_ext_addr,
    input wire logic [7:0] i_ext_wdata,
    output logic [7:0] o_ext_rdata,
    output logic o_ext_done,
    output logic o_ext_busy,
    input wire logic [1:0] i_sio0_mode,
    input wire logic i_serial0_out,
    input wire logic i_serial0_clock_out,
    input wire logic i_serial0_clock_master,
    output logic o_serial0_in,
    output logic o_serial0_clock_in,
    input wire logic i_auto_xfer_en,
    input wire logic i_auto_xfer_strobe,
    output logic o_auto_xfer_busy,
    input wire logic i_timer16_out_en,
    input wire logic i_timer16_out
);
    localparam int P = ppm_pkg::PINS;

    if (PORT_WIDTH != ppm_pkg::PORT_W) begin : g_width_check
        $error("PORT_WIDTH must be 8");
    end

    // ========================================
    // pin synchronisers
    logic [P-1:0] pin_meta_r;
    logic [P-1:0] pin_r;
    logic [P-1:0] pin_prev_r;
    always_ff @(posedge i_mclk) begin
        pin_meta_r <= i_pin_in;
        pin_r <= pin_meta_r;
        pin_prev_r <= pin_r;
    end

    // ========================================
    // software latches, modes and pull-ups
    logic [P-1:0] latch_r;
    logic [P-1:0] mode_in_r;
    logic [P-1:0] pullup_r;
    genvar gp;
    for (gp = 0; gp < ppm_pkg::NUM_PORTS; gp++) begin : g_port
        always_ff @(posedge i_mclk) begin
            if (!i_nrst) begin
                latch_r[gp*8 +: 8] <= ppm_pkg::LATCH_RST;
                mode_in_r[gp*8 +: 8] <= ppm_pkg::MODE_RST;
                pullup_r[gp*8 +: 8] <= ppm_pkg::PULLUP_RST;
            end else if (i_port_sel == 3'(gp)) begin
                if (i_latch_wr) begin
                    latch_r[gp*8 +: 8] <= i_wdata;
                end
                if (i_mode_wr) begin
                    if (3'(gp) == ppm_pkg::PORT4) begin
                        mode_in_r[gp*8 +: 8] <= {8{i_wdata[0]}};
                    end else if (3'(gp) == ppm_pkg::PORT0) begin
                        mode_in_r[gp*8 +: 8] <= {3'h7, 1'b1, i_wdata[3:1], 1'b1};
                    end else begin
                        mode_in_r[gp*8 +: 8] <= i_wdata;
                    end
                end
                if (i_pullup_wr) begin
                    pullup_r[gp*8 +: 8] <= i_wdata;
                end
            end
        end
    end

    // ========================================
    // memory size settings
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            o_memory_size_select <= ppm_pkg::MEM_SIZE_RST;
            o_expansion_ram_size_select <= ppm_pkg::EXP_RAM_SIZE_RST;
        end else begin
            if (i_mem_size_wr) begin
                o_memory_size_select <= i_wdata;
            end
            if (i_exp_ram_size_wr) begin
                o_expansion_ram_size_select <= i_wdata;
            end
        end
    end

    // ========================================
    // programming mode entry, sampled without reset so it works while reset is held
    logic vpp_meta_r;
    logic vpp_r;
    always_ff @(posedge i_mclk) begin
        vpp_meta_r <= i_vpp_prog;
        vpp_r <= vpp_meta_r;
        o_prog_mode <= vpp_r & ~i_nrst;
        o_prog_addr <= {pin_r[ppm_pkg::PIN_PROG_A16], pin_r[ppm_pkg::BASE_P2 +: 8],
                        pin_r[ppm_pkg::BASE_P1 +: 8]};
        o_prog_wdata <= pin_r[ppm_pkg::BASE_P4 +: 8];
        o_prog_ce_n <= pin_r[ppm_pkg::PIN_PROG_CE];
        o_prog_oe_n <= pin_r[ppm_pkg::PIN_PROG_OE];
        o_prog_pgm_n <= pin_r[ppm_pkg::PIN_PROG_PGM];
    end

    // ========================================
    // key return flag and external interrupts
    function automatic logic edge_hit(input logic prev, input logic cur, input logic [1:0] sel);
        logic rise;
        logic fall;
        rise = ~prev & cur;
        fall = prev & ~cur;
        if (sel == ppm_pkg::EDGE_FALL) begin
            edge_hit = fall;
        end else if (sel == ppm_pkg::EDGE_RISE) begin
            edge_hit = rise;
        end else begin
            edge_hit = rise | fall;
        end
    endfunction

    logic p4_fall;
    assign p4_fall = |(pin_prev_r[ppm_pkg::BASE_P4 +: 8] & ~pin_r[ppm_pkg::BASE_P4 +: 8]);
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            o_key_return_flag <= 1'b0;
        end else if (p4_fall) begin
            o_key_return_flag <= 1'b1;
        end else if (i_key_return_clr) begin
            o_key_return_flag <= 1'b0;
        end
    end

    genvar gi;
    for (gi = 0; gi < 3; gi++) begin : g_irq
        always_ff @(posedge i_mclk) begin
            if (!i_nrst) begin
                o_ext_irq[gi] <= 1'b0;
            end else begin
                o_ext_irq[gi] <= edge_hit(pin_prev_r[ppm_pkg::PIN_P00 + gi],
                                          pin_r[ppm_pkg::PIN_P00 + gi],
                                          i_ext_irq_edge[gi*2 +: 2]);
            end
        end
    end
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            o_ext_irq[3] <= 1'b0;
        end else begin
            o_ext_irq[3] <= edge_hit(pin_prev_r[3], pin_r[3], ppm_pkg::EDGE_FALL);
        end
    end

    // ========================================
    // external memory access sequencer
    ppm_pkg::ppm_bus_state_t bus_state_r;
    logic [15:0] bus_addr_r;
    logic [7:0] bus_wdata_r;
    logic bus_write_r;
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            bus_state_r <= ppm_pkg::PPM_BUS_IDLE;
            bus_addr_r <= 16'h0000;
            bus_wdata_r <= 8'h00;
            bus_write_r <= 1'b0;
            o_ext_rdata <= 8'h00;
            o_ext_done <= 1'b0;
        end else begin
            o_ext_done <= 1'b0;
            case (bus_state_r)
                ppm_pkg::PPM_BUS_IDLE: begin
                    if (i_ext_bus_en && (i_ext_rd_req || i_ext_wr_req)) begin
                        bus_addr_r <= i_ext_addr;
                        bus_wdata_r <= i_ext_wdata;
                        bus_write_r <= i_ext_wr_req;
                        bus_state_r <= ppm_pkg::PPM_BUS_ADDR;
                    end
                end
                ppm_pkg::PPM_BUS_ADDR: begin
                    bus_state_r <= ppm_pkg::PPM_BUS_STROBE;
                end
                ppm_pkg::PPM_BUS_STROBE: begin
                    if (pin_r[ppm_pkg::PIN_WAIT_N] &&
                        !(o_pin_out[ppm_pkg::PIN_RD_N] & o_pin_out[ppm_pkg::PIN_WR_N])) begin
                        o_ext_rdata <= pin_r[ppm_pkg::BASE_P4 +: 8];
                        o_ext_done <= 1'b1;
                        bus_state_r <= ppm_pkg::PPM_BUS_DONE;
                    end
                end
                default: begin
                    bus_state_r <= ppm_pkg::PPM_BUS_IDLE;
                end
            endcase
        end
    end
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            o_ext_busy <= 1'b0;
        end else begin
            o_ext_busy <= (bus_state_r != ppm_pkg::PPM_BUS_IDLE);
        end
    end

    // ========================================
    // pin drive: ports, alternate functions, bus and programming overrides
    logic [P-1:0] out_nxt;
    logic [P-1:0] oe_nxt;
    logic [P-1:0] pu_nxt;
    logic bus_on;
    logic bus_addr_ph;
    logic bus_strb_ph;
    logic od_line;
    always_comb begin
        bus_on = i_ext_bus_en;
        bus_addr_ph = (bus_state_r == ppm_pkg::PPM_BUS_ADDR);
        bus_strb_ph = (bus_state_r == ppm_pkg::PPM_BUS_STROBE);
        od_line = 1'b0;
        for (int i = 0; i < P; i++) begin
            out_nxt[i] = latch_r[i];
            oe_nxt[i] = ~mode_in_r[i];
            pu_nxt[i] = pullup_r[i] & mode_in_r[i];
        end
        for (int i = ppm_pkg::PORT0_W; i < 8; i++) begin
            oe_nxt[i] = 1'b0;
            pu_nxt[i] = 1'b0;
        end
        oe_nxt[ppm_pkg::PIN_P00] = 1'b0;
        oe_nxt[ppm_pkg::PIN_P04] = 1'b0;
        if (i_analog_en) begin
            pu_nxt[ppm_pkg::BASE_P1 +: 8] = 8'h00;
        end
        for (int i = ppm_pkg::OD_FIRST; i <= ppm_pkg::OD_LAST; i++) begin
            out_nxt[i] = 1'b0;
            oe_nxt[i] = ~mode_in_r[i] & ~latch_r[i];
        end
        if (i_auto_xfer_en) begin
            out_nxt[ppm_pkg::PIN_AUTO_STROBE] = i_auto_xfer_strobe;
        end
        if (i_timer16_out_en) begin
            out_nxt[ppm_pkg::PIN_TIMER16_OUT] = i_timer16_out;
        end
        case (ppm_pkg::ppm_sio_mode_t'(i_sio0_mode))
            ppm_pkg::PPM_SIO_3WIRE: begin
                oe_nxt[ppm_pkg::PIN_SERIAL0_IN] = 1'b0;
                out_nxt[ppm_pkg::PIN_SERIAL0_OUT] = i_serial0_out;
                out_nxt[ppm_pkg::PIN_SERIAL0_CLK] = i_serial0_clock_out;
                oe_nxt[ppm_pkg::PIN_SERIAL0_CLK] = i_serial0_clock_master;
            end
            ppm_pkg::PPM_SIO_2WIRE, ppm_pkg::PPM_SIO_I2C: begin
                od_line = (ppm_pkg::ppm_sio_mode_t'(i_sio0_mode) == ppm_pkg::PPM_SIO_I2C);
                out_nxt[ppm_pkg::PIN_SERIAL0_IN] = 1'b0;
                oe_nxt[ppm_pkg::PIN_SERIAL0_IN] = ~i_serial0_out;
                out_nxt[ppm_pkg::PIN_SERIAL0_CLK] = od_line ? 1'b0 : i_serial0_clock_out;
                oe_nxt[ppm_pkg::PIN_SERIAL0_CLK] = i_serial0_clock_master &
                    (od_line ? ~i_serial0_clock_out : 1'b1);
            end
            default: begin
            end
        endcase
        if (bus_on) begin
            out_nxt[ppm_pkg::BASE_P4 +: 8] = bus_addr_ph ? bus_addr_r[7:0] : bus_wdata_r;
            oe_nxt[ppm_pkg::BASE_P4 +: 8] = {8{bus_addr_ph | (bus_strb_ph & bus_write_r)}};
            out_nxt[ppm_pkg::BASE_P5 +: 8] = bus_addr_r[15:8];
            oe_nxt[ppm_pkg::BASE_P5 +: 8] = 8'hff;
            out_nxt[ppm_pkg::PIN_RD_N] = ~(bus_strb_ph & ~bus_write_r);
            out_nxt[ppm_pkg::PIN_WR_N] = ~(bus_strb_ph & bus_write_r);
            out_nxt[ppm_pkg::PIN_ADDR_LATCH] = bus_addr_ph;
            oe_nxt[ppm_pkg::PIN_RD_N] = 1'b1;
            oe_nxt[ppm_pkg::PIN_WR_N] = 1'b1;
            oe_nxt[ppm_pkg::PIN_ADDR_LATCH] = 1'b1;
            oe_nxt[ppm_pkg::PIN_WAIT_N] = 1'b0;
            pu_nxt[ppm_pkg::BASE_P4 +: 8] = 8'h00;
            pu_nxt[ppm_pkg::BASE_P5 +: 8] = 8'h00;
        end
        pu_nxt = pu_nxt & ~oe_nxt;
        if (o_prog_mode) begin
            out_nxt = '0;
            oe_nxt = '0;
            pu_nxt = '0;
            out_nxt[ppm_pkg::BASE_P4 +: 8] = i_prog_rdata;
            oe_nxt[ppm_pkg::BASE_P4 +: 8] = {8{~o_prog_ce_n & ~o_prog_oe_n}};
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_nrst || o_prog_mode) begin
            o_pin_out <= out_nxt;
            o_pin_oe <= oe_nxt;
            o_pin_pullup <= pu_nxt;
        end else begin
            o_pin_out <= '0;
            o_pin_oe <= '0;
            o_pin_pullup <= '0;
        end
    end

    // ========================================
    // port read back and sampled alternate inputs
    logic [7:0] rd_pins;
    logic [7:0] rd_mode;
    logic [7:0] rd_latch;
    always_comb begin
        rd_pins = pin_r[i_port_sel*8 +: 8];
        rd_mode = mode_in_r[i_port_sel*8 +: 8];
        rd_latch = latch_r[i_port_sel*8 +: 8];
        if (i_port_sel == ppm_pkg::PORT0) begin
            rd_pins[7:5] = 3'h0;
            rd_pins[4] = rd_pins[4] & i_feedback_resistor_cut;
        end
    end
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            o_port_rdata <= 8'h00;
            o_serial0_in <= 1'b0;
            o_serial0_clock_in <= 1'b0;
            o_auto_xfer_busy <= 1'b0;
        end else begin
            o_port_rdata <= (rd_mode & rd_pins) | (~rd_mode & rd_latch);
            o_serial0_in <= pin_r[ppm_pkg::PIN_SERIAL0_IN];
            o_serial0_clock_in <= pin_r[ppm_pkg::PIN_SERIAL0_CLK];
            o_auto_xfer_busy <= pin_r[ppm_pkg::PIN_AUTO_BUSY];
        end
    end
endmodule
`default_nettype wire

// [dv/ppm_port_mux_properties.sv]
// port-level assertions for the port pin mux and control block
`timescale 1ns/1ps
`default_nettype none
module ppm_port_mux_properties (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic [55:0] i_pin_in,
    input wire logic [55:0] o_pin_out,
    input wire logic [55:0] o_pin_oe,
    input wire logic [55:0] o_pin_pullup,
    input wire logic [7:0] o_memory_size_select,
    input wire logic [7:0] o_expansion_ram_size_select,
    input wire logic i_analog_en,
    input wire logic o_key_return_flag,
    input wire logic [5:0] i_ext_irq_edge,
    input wire logic [3:0] o_ext_irq,
    input wire logic i_vpp_prog,
    input wire logic o_prog_mode,
    input wire logic o_ext_done
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);
    // ========================================
    // sequences
    sequence p4_fall;
        |($past(i_pin_in[39:32]) & ~i_pin_in[39:32]);
    endsequence
    sequence bus_addr;
        o_pin_oe[55] && $rose(o_pin_out[55]);
    endsequence
    sequence bus_strobe;
        o_pin_oe[52] && o_pin_oe[53] && !(o_pin_out[52] && o_pin_out[53]);
    endsequence
    // ========================================
    // assertions
    port0_in_only_a: assert property (!o_pin_oe[0] && !o_pin_oe[4])
        else $error("port 0 input-only pin driven");
    port4_whole_a: assert property (o_pin_oe[39:32] == 8'h00 || o_pin_oe[39:32] == 8'hff)
        else $error("port 4 direction split");
    key_flag_set_a: assert property (p4_fall |-> ##[1:6] o_key_return_flag)
        else $error("port 4 falling edge did not set key flag");
    pullup_input_a: assert property ((o_pin_pullup & o_pin_oe) == 56'h0)
        else $error("pull-up on a driven pin");
    reset_inputs_a: assert property (disable iff (1'b0)
        (!i_nrst && !i_vpp_prog) [*4] |=> o_pin_oe == 56'h0 && o_pin_pullup == 56'h0)
        else $error("pin not input after reset");
    reset_sizes_a: assert property (disable iff (1'b0) !i_nrst |=>
        o_memory_size_select == 8'hcf && o_expansion_ram_size_select == 8'h0a)
        else $error("memory size reset value wrong");
    analog_pullup_a: assert property (i_analog_en [*2] |=> o_pin_pullup[15:8] == 8'h00)
        else $error("port 1 pull-up kept in analog use");
    irq_rise_a: assert property ($rose(i_pin_in[1]) && i_ext_irq_edge[3:2] != 2'h0
        |-> ##[2:5] o_ext_irq[1])
        else $error("selected rising edge gave no interrupt");
    irq_fall_a: assert property ($fell(i_pin_in[2]) && i_ext_irq_edge[5:4] != 2'h1
        |-> ##[2:5] o_ext_irq[2])
        else $error("selected falling edge gave no interrupt");
    irq3_fall_only_a: assert property ((!i_pin_in[3]) [*6] ##1 i_pin_in[3]
        |-> (!o_ext_irq[3]) [*5])
        else $error("interrupt 3 fired on a rising edge");
    bus_cycle_a: assert property (bus_addr |-> o_pin_oe[47:32] == 16'hffff ##1 bus_strobe)
        else $error("address phase or strobe phase wrong");
    wait_hold_a: assert property ((!i_pin_in[54]) [*5] |-> !o_ext_done)
        else $error("access ended while wait held");
    prom_entry_a: assert property (disable iff (1'b0)
        (i_vpp_prog && !i_nrst) [*4] |-> o_prog_mode)
        else $error("programming mode not entered");
endmodule
bind ppm_port_mux ppm_port_mux_properties u_props (.i_mclk, .i_nrst, .i_pin_in, .o_pin_out,
    .o_pin_oe, .o_pin_pullup, .o_memory_size_select, .o_expansion_ram_size_select,
    .i_analog_en, .o_key_return_flag, .i_ext_irq_edge, .o_ext_irq, .i_vpp_prog,
    .o_prog_mode, .o_ext_done);
`default_nettype wire

// [dv/ppm_pin_model.sv]
// behavioural model of circuitry and memory at the port pins
`timescale 1ns/1ps
`default_nettype none
module ppm_pin_model (
    input wire logic i_mclk,
    input wire logic [55:0] i_drv,
    input wire logic [55:0] i_oe,
    input wire logic [55:0] i_pu,
    input wire logic [55:0] i_ext_val,
    input wire logic [55:0] i_ext_en,
    input wire logic [3:0] i_wait_len,
    output logic [55:0] o_level,
    output logic [7:0] o_hi_addr
);
    logic [7:0] mem [256];
    logic [7:0] addr_r = 8'h00;
    logic [55:0] float_r = 56'h0;
    logic [3:0] wait_r = 4'h0;
    logic idle;
    assign idle = !(i_oe[55] && i_drv[55]) && !(i_oe[52] && !i_drv[52]) && !(i_oe[53] && !i_drv[53]);
    always_ff @(posedge i_mclk) begin
        // released pins show a changing value
        float_r <= ~o_level;
        if (i_oe[55] && i_drv[55]) begin
            addr_r <= i_drv[39:32];
            o_hi_addr <= i_drv[47:40];
        end
        if (i_oe[53] && !i_drv[53]) mem[addr_r] <= i_drv[39:32];
        if (idle) wait_r <= i_wait_len;
        else if (wait_r != 4'h0) wait_r <= wait_r - 4'h1;
    end
    always_comb begin
        for (int i = 0; i < 56; i++)
            o_level[i] = i_oe[i] ? i_drv[i] : i_ext_en[i] ? i_ext_val[i] : i_pu[i] | float_r[i];
        if (i_oe[52] && !i_drv[52] && i_oe[39:32] == 8'h00) o_level[39:32] = mem[addr_r];
        o_level[54] = idle || wait_r == 4'h0;
    end
endmodule
`default_nettype wire

// [dv/test_ppm_port_mux.sv]
// self-checking testbench for the port pin mux and control block
`timescale 1ns/1ps
`default_nettype none
module test_ppm_port_mux;
    logic i_mclk = 1'h0, i_nrst = 1'h0, i_latch_wr = 1'h0, i_mode_wr = 1'h0, i_pullup_wr = 1'h0;
    logic i_mem_size_wr = 1'h0, i_exp_ram_size_wr = 1'h0, i_feedback_resistor_cut = 1'h0;
    logic i_analog_en = 1'h0, i_key_return_clr = 1'h0, i_vpp_prog = 1'h0, i_ext_bus_en = 1'h0;
    logic i_ext_rd_req = 1'h0, i_ext_wr_req = 1'h0, i_serial0_out = 1'h0, i_serial0_clock_out = 1'h0;
    logic i_serial0_clock_master = 1'h0, i_auto_xfer_en = 1'h0, i_auto_xfer_strobe = 1'h0;
    logic i_timer16_out_en = 1'h0, i_timer16_out = 1'h0;
    logic [2:0] i_port_sel = 3'h0;
    logic [7:0] i_wdata = 8'h00, i_prog_rdata = 8'h3c, i_ext_wdata = 8'h00;
    logic [5:0] i_ext_irq_edge = 6'h0;
    logic [15:0] i_ext_addr = 16'h0;
    logic [1:0] i_sio0_mode = 2'h0;
    logic [3:0] wait_len = 4'h6;
    logic [55:0] i_pin_in, o_pin_out, o_pin_oe, o_pin_pullup;
    logic [55:0] ext_en = 56'h0000ff0000001f, ext_val = 56'h0000ff00000000;
    logic [7:0] o_port_rdata, o_memory_size_select, o_expansion_ram_size_select, o_prog_wdata;
    logic [7:0] o_ext_rdata, hi_addr;
    logic [3:0] o_ext_irq;
    logic [16:0] o_prog_addr;
    logic o_key_return_flag, o_prog_mode, o_prog_ce_n, o_prog_oe_n, o_prog_pgm_n, o_ext_done;
    logic o_ext_busy, o_serial0_in, o_serial0_clock_in, o_auto_xfer_busy;
    int fails = 0, compares = 0, cyc = 0;
    int irq_cnt [4];
    ppm_port_mux u_dut (.*);
    ppm_pin_model u_pins (.i_mclk, .i_drv(o_pin_out), .i_oe(o_pin_oe), .i_pu(o_pin_pullup),
        .i_ext_val(ext_val), .i_ext_en(ext_en), .i_wait_len(wait_len), .o_level(i_pin_in),
        .o_hi_addr(hi_addr));
    always #12.5 i_mclk = ~i_mclk;
    always @(posedge i_mclk) begin
        for (int b = 0; b < 4; b++) if (o_ext_irq[b] === 1'h1) irq_cnt[b]++;
        cyc++;
        if (cyc == 3000) begin
            fails++;
            close_out();
        end
    end
    // ========================================
    // tasks
    task automatic close_out;
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input logic [55:0] got, input logic [55:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(negedge i_mclk);
    endtask
    // kind 0 latch, 1 mode, 2 pull-up, 3 memory size, 4 expansion ram size
    task automatic wr(input int k, input logic [2:0] s, input logic [7:0] d);
        @(negedge i_mclk);
        i_port_sel = s;
        i_wdata = d;
        {i_exp_ram_size_wr, i_mem_size_wr, i_pullup_wr, i_mode_wr, i_latch_wr} = 5'h1 << k;
        @(negedge i_mclk);
        {i_exp_ram_size_wr, i_mem_size_wr, i_pullup_wr, i_mode_wr, i_latch_wr} = 5'h0;
        wait_n(3);
    endtask
    task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(negedge i_mclk);
        i_ext_addr = a;
        i_ext_wdata = d;
        i_ext_wr_req = w;
        i_ext_rd_req = !w;
        while (o_ext_busy !== 1'h1 && n < 20) begin
            @(negedge i_mclk);
            n++;
        end
        i_ext_wr_req = 1'h0;
        i_ext_rd_req = 1'h0;
        while (o_ext_done !== 1'h1 && n < 60) begin
            @(negedge i_mclk);
            n++;
        end
        check(n < 60, 1'h1);
        wait_n(2);
    endtask
    // ========================================
    // main sequence
    initial begin
        wait_n(4);
        i_nrst = 1'h1;
        wait_n(1);
        check(o_pin_oe, 56'h0);
        check(o_pin_pullup, 56'h0);
        check(o_memory_size_select, 8'hcf);
        check(o_expansion_ram_size_select, 8'h0a);
        wr(3, 3'h0, 8'h42);
        check(o_memory_size_select, 8'h42);
        wr(4, 3'h0, 8'h0c);
        check(o_expansion_ram_size_select, 8'h0c);
        wr(1, 3'h0, 8'h00);
        check(o_pin_oe[4:0], 5'h0e);
        wr(1, 3'h0, 8'hff);
        ext_val[4:0] = 5'h10;
        i_feedback_resistor_cut = 1'h1;
        wait_n(4);
        check(o_port_rdata, 8'h10);
        i_feedback_resistor_cut = 1'h0;
        wait_n(4);
        check(o_port_rdata, 8'h00);
        for (int c = 0; c < 3; c++) begin
            i_ext_irq_edge = {3{c[1:0]}};
            wait_n(8);
            irq_cnt = '{default: 0};
            ext_val[3:0] = 4'hf;
            wait_n(8);
            ext_val[3:0] = 4'h0;
            wait_n(8);
            for (int b = 0; b < 3; b++) check(irq_cnt[b], (c != 0) + (c != 1));
            check(irq_cnt[3], 1);
        end
        wr(1, 3'h4, 8'hfe);
        check(o_pin_oe[39:32], 8'hff);
        wr(1, 3'h4, 8'h01);
        check(o_pin_oe[39:32], 8'h00);
        i_key_return_clr = 1'h1;
        wait_n(1);
        i_key_return_clr = 1'h0;
        wait_n(2);
        check(o_key_return_flag, 1'h0);
        ext_val[35] = 1'h0;
        wait_n(6);
        check(o_key_return_flag, 1'h1);
        wr(2, 3'h1, 8'hff);
        check(o_pin_pullup[15:8], 8'hff);
        i_analog_en = 1'h1;
        wait_n(3);
        check(o_pin_pullup[15:8], 8'h00);
        wr(2, 3'h2, 8'hff);
        wr(1, 3'h2, 8'h0f);
        check(o_pin_pullup[23:16], 8'h0f);
        wr(0, 3'h2, 8'ha5);
        check(o_port_rdata, 8'haf);
        wr(1, 3'h2, 8'h30);
        wr(0, 3'h2, 8'h00);
        ext_en[21:20] = 2'h3;
        ext_val[21:20] = 2'h3;
        i_sio0_mode = ppm_pkg::PPM_SIO_3WIRE;
        {i_serial0_out, i_serial0_clock_master, i_serial0_clock_out} = 3'h7;
        {i_auto_xfer_en, i_auto_xfer_strobe} = 2'h3;
        wait_n(4);
        check({o_auto_xfer_busy, o_serial0_in, o_pin_out[23:22], o_pin_out[19]}, 5'h1f);
        {i_sio0_mode, i_serial0_out} = 3'h6;
        wait_n(3);
        check({o_pin_oe[21], o_pin_out[21], o_pin_oe[23]}, 3'h4);
        wr(1, 3'h3, 8'hfe);
        {i_timer16_out_en, i_timer16_out} = 2'h3;
        wait_n(3);
        check({o_pin_oe[24], o_pin_out[24]}, 2'h3);
        i_timer16_out = 1'h0;
        wait_n(3);
        check(o_pin_out[24], 1'h0);
        ext_en[39:32] = 8'h00;
        i_ext_bus_en = 1'h1;
        bus(1'h1, 16'h1234, 8'h5c);
        bus(1'h0, 16'h1234, 8'h00);
        check(o_ext_rdata, 8'h5c);
        check(hi_addr, 8'h12);
        i_ext_bus_en = 1'h0;
        // programmer sets address, enables and supply with reset held low
        ext_en[27:8] = 20'hfffff;
        ext_val[27:8] = 20'hc1234;
        i_vpp_prog = 1'h1;
        i_nrst = 1'h0;
        wait_n(7);
        check(o_prog_mode, 1'h1);
        check({o_prog_wdata, o_prog_ce_n, o_prog_oe_n, o_prog_pgm_n}, 11'h1e1);
        check(o_prog_addr, 17'h11234);
        check({o_pin_oe[39:32], o_pin_out[39:32]}, {8'hff, i_prog_rdata});
        i_vpp_prog = 1'h0;
        i_nrst = 1'h1;
        wait_n(5);
        check(o_prog_mode, 1'h0);
        close_out();
    end
endmodule
`default_nettype wire
